// ### common/port_cfg_pkg.sv
package port_cfg_pkg;

    // Register byte addresses (printed offsets are byte addresses)
    localparam logic [7:0] CTRL2_ADDR = 8'h42;
    localparam logic [7:0] CTRL3_ADDR = 8'h44;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [15:0] CTRL3_RESET = 16'h0000;
    localparam logic [15:0] CTRL2_WMASK = 16'h8CFF;
    localparam logic [15:0] CTRL3_WMASK = 16'h3FE0;

    // Control two field positions
    localparam int LINE_EN_BIT = 15;
    localparam int VCNT_BIT = 11;
    localparam int LMODE_BIT = 10;
    localparam int CDIS_BIT = 7;
    localparam int PSEL_BIT = 6;
    // Control three field positions
    localparam int RX_CLK_SEL_BIT = 13;
    localparam int RFRS_BIT = 12;
    localparam int RAUX_BIT = 11;
    localparam int TX_CLK_SEL_BIT = 10;
    localparam int TFRS_BIT = 9;
    localparam int TAUX_BIT = 8;
    localparam int SRC_HI = 7;
    localparam int USEP_BIT = 5;

    // Good cell counts for delineation verify
    localparam logic [3:0] VERIFY_SIX = 4'h6;
    localparam logic [3:0] VERIFY_EIGHT = 4'h8;

    typedef enum logic [1:0] {
        CODE_B3ZS_HDB3 = 2'b00,
        CODE_AMI = 2'b01,
        CODE_UNI = 2'b10
    } line_code_t;

    typedef enum logic [2:0] {
        FR_DS3_CBIT = 3'b000,
        FR_DS3_M23 = 3'b001,
        FR_E3_G751 = 3'b010,
        FR_E3_G832 = 3'b011,
        FR_CC_DS3 = 3'b100,
        FR_CC_STS1 = 3'b101,
        FR_CC_E3 = 3'b110
    } frame_family_t;

    typedef enum logic [2:0] {
        SUB_PLAIN = 3'b000,
        SUB_MASK = 3'b001,
        SUB_INT_FRAC = 3'b010,
        SUB_EXT_FRAC = 3'b011,
        SUB_PLCP = 3'b100,
        SUB_PLCP_MASK = 3'b101,
        SUB_FLEX_FRAC = 3'b110,
        SUB_MASK_OCTET = 3'b111
    } frame_sub_t;

    typedef enum logic [1:0] {
        REF_RX_PLCP = 2'b00,
        REF_RX_LINE = 2'b10,
        REF_TX_FRAMER = 2'b11
    } ref_src_t;

    // Decoded configuration carried to the datapath
    typedef struct packed {
        frame_family_t family;
        frame_sub_t sub;
        logic plcp;
        logic overhead_mask;
        line_code_t code;
        logic cell_proc;
        logic proc_delineates;
        logic [3:0] verify_count;
    } mode_cfg_t;

    typedef struct packed {
        logic tx_line_out_enable;
        logic rx_clk_pin_select;
        logic rx_frame_pin_select;
        logic rx_aux_port_enable;
        logic tx_clk_pin_select;
        logic tx_frame_pin_select;
        logic tx_aux_port_enable;
        logic ref8k_use_port;
        logic [1:0] ref8k_port_source;
    } pin_cfg_t;

endpackage

// ### rtl/port_config_regs.sv
`timescale 1ns/1ps

module port_config_regs
    import port_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic packet_bus_mode_i,
    input wire logic zero_suppress_disable_i,
    input wire logic tx_line_clock_i,
    input wire logic tx_positive_i,
    input wire logic tx_negative_i,
    input wire logic rx_overhead_clock_i,
    input wire logic rx_gapped_clock_i,
    input wire logic rx_clock_output_i,
    input wire logic rx_start_of_frame_i,
    input wire logic rx_data_enable_i,
    input wire logic tx_overhead_clock_i,
    input wire logic tx_gapped_clock_i,
    input wire logic tx_clock_output_i,
    input wire logic tx_start_of_frame_i,
    input wire logic tx_data_enable_i,
    input wire logic ohclk_not_gapped_i,
    input wire logic rx_clk_drive_low_i,
    input wire logic rx_plcp_8k_i,
    input wire logic rx_line_clock_in_i,
    input wire logic tx_framer_8k_i,
    input wire logic global_8k_i,
    output logic tx_line_clock_out_o,
    output logic tx_positive_out_o,
    output logic tx_negative_out_o,
    output logic rx_clk_pin_o,
    output logic rx_frame_pin_o,
    output logic tx_clk_pin_o,
    output logic tx_frame_pin_o,
    output logic rx_aux_port_enable_o,
    output logic tx_aux_port_enable_o,
    output logic ref8k_port_o,
    output logic ref8k_local_o,
    output mode_cfg_t mode_o,
    output pin_cfg_t pins_o,
    input wire logic [3:0] good_cells_i,
    output logic verify_done_o
);

    typedef struct packed {
        logic [15:0] ctrl2;
        logic [15:0] ctrl3;
        logic [31:0] rdata;
        logic ack;
        mode_cfg_t mode;
        pin_cfg_t pins;
        logic tlclk;
        logic tpos;
        logic tneg;
        logic rclk_pin;
        logic rfr_pin;
        logic tclk_pin;
        logic tfr_pin;
        logic ref_port;
        logic ref_local;
        logic vdone;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be, input logic [15:0] wm);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}} & wm;
        merge16 = (old & ~m) | (wd & m);
    endfunction

    // Framing mode decode, reserved codes become the default
    function automatic mode_cfg_t decode_mode(input logic [15:0] c2, input logic pbus,
                                              input logic zsd);
        mode_cfg_t r;
        logic [5:0] fm;
        fm = c2[5:0];
        r = '0;
        r.family = FR_DS3_CBIT;
        r.sub = SUB_PLAIN;
        if (!fm[5]) begin
            r.family = frame_family_t'({1'b0, fm[4:3]});
            r.sub = frame_sub_t'(fm[2:0]);
            if (fm[2:0] == 3'b111 || (fm[4:3] == 2'b11 && fm[2:1] == 2'b10)) begin
                r.family = FR_DS3_CBIT;
                r.sub = SUB_PLAIN;
            end
        end else if (!fm[2]) begin
            r.family = fm[4] ? FR_CC_E3 : (fm[3] ? FR_CC_STS1 : FR_CC_DS3);
            case (fm[1:0])
                2'b01: r.sub = SUB_MASK;
                2'b11: r.sub = SUB_MASK_OCTET;
                default: r.sub = SUB_PLAIN;
            endcase
        end
        r.plcp = (r.sub == SUB_PLCP) || (r.sub == SUB_PLCP_MASK);
        r.overhead_mask = (r.sub == SUB_MASK) || (r.sub == SUB_PLCP_MASK) ||
                          (r.sub == SUB_MASK_OCTET);
        // Line code choice
        if (c2[LMODE_BIT] || r.overhead_mask) begin
            r.code = CODE_UNI;
        end else begin
            r.code = zsd ? CODE_AMI : CODE_B3ZS_HDB3;
        end
        // Cells always outside bus mode; PLCP forces cells
        r.cell_proc = !pbus || r.plcp || c2[PSEL_BIT];
        r.proc_delineates = !r.plcp || !c2[CDIS_BIT];
        r.verify_count = c2[VCNT_BIT] ? VERIFY_EIGHT : VERIFY_SIX;
        decode_mode = r;
    endfunction

    // Next-state logic: bus slave, decode and pin steering
    always_comb begin
        logic hit;
        logic en;
        logic [1:0] src;
        hit = 1'b0;
        en = 1'b0;
        src = 2'b00;
        s_d = s_q;
        hit = cyc_i && stb_i && !s_q.ack;
        s_d.ack = hit;
        s_d.rdata = 32'h0000_0000;
        if (hit && we_i) begin
            if (adr_i == CTRL2_ADDR) begin
                s_d.ctrl2 = merge16(s_q.ctrl2, dat_i[15:0], sel_i[1:0], CTRL2_WMASK);
            end else if (adr_i == CTRL3_ADDR) begin
                s_d.ctrl3 = merge16(s_q.ctrl3, dat_i[15:0], sel_i[1:0], CTRL3_WMASK);
            end
        end
        if (hit && !we_i) begin
            if (adr_i == CTRL2_ADDR) begin
                s_d.rdata = {16'h0000, s_q.ctrl2};
            end else if (adr_i == CTRL3_ADDR) begin
                s_d.rdata = {16'h0000, s_q.ctrl3};
            end
        end
        s_d.mode = decode_mode(s_q.ctrl2, packet_bus_mode_i, zero_suppress_disable_i);
        s_d.pins.tx_line_out_enable = s_q.ctrl2[LINE_EN_BIT];
        s_d.pins.rx_clk_pin_select = s_q.ctrl3[RX_CLK_SEL_BIT];
        s_d.pins.rx_frame_pin_select = s_q.ctrl3[RFRS_BIT];
        s_d.pins.rx_aux_port_enable = s_q.ctrl3[RAUX_BIT];
        s_d.pins.tx_clk_pin_select = s_q.ctrl3[TX_CLK_SEL_BIT];
        s_d.pins.tx_frame_pin_select = s_q.ctrl3[TFRS_BIT];
        s_d.pins.tx_aux_port_enable = s_q.ctrl3[TAUX_BIT];
        s_d.pins.ref8k_use_port = s_q.ctrl3[USEP_BIT];
        s_d.pins.ref8k_port_source = s_q.ctrl3[SRC_HI:SRC_HI-1];
        // Line outputs held low while disabled
        en = s_q.ctrl2[LINE_EN_BIT];
        s_d.tlclk = en & tx_line_clock_i;
        s_d.tpos = en & tx_positive_i;
        s_d.tneg = en & tx_negative_i;
        // Shared receive pins
        if (s_q.ctrl3[RX_CLK_SEL_BIT]) begin
            s_d.rclk_pin = rx_clock_output_i;
        end else if (rx_clk_drive_low_i) begin
            s_d.rclk_pin = 1'b0;
        end else begin
            s_d.rclk_pin = ohclk_not_gapped_i ? rx_overhead_clock_i : rx_gapped_clock_i;
        end
        s_d.rfr_pin = s_q.ctrl3[RFRS_BIT] ? rx_start_of_frame_i : rx_data_enable_i;
        // Shared transmit pins
        if (s_q.ctrl3[TX_CLK_SEL_BIT]) begin
            s_d.tclk_pin = tx_clock_output_i;
        end else begin
            s_d.tclk_pin = ohclk_not_gapped_i ? tx_overhead_clock_i : tx_gapped_clock_i;
        end
        s_d.tfr_pin = s_q.ctrl3[TFRS_BIT] ? tx_start_of_frame_i : tx_data_enable_i;
        // 8 kHz reference choice
        src = s_q.ctrl3[SRC_HI:SRC_HI-1];
        if (!src[1]) begin
            s_d.ref_port = rx_plcp_8k_i;
        end else if (!src[0]) begin
            s_d.ref_port = rx_line_clock_in_i;
        end else begin
            s_d.ref_port = tx_framer_8k_i;
        end
        s_d.ref_local = s_q.ctrl3[USEP_BIT] ? s_q.ref_port : global_8k_i;
        s_d.vdone = (good_cells_i >= s_d.mode.verify_count);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.ctrl2 <= CTRL2_RESET;
            s_q.ctrl3 <= CTRL3_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign mode_o = s_q.mode;
    assign pins_o = s_q.pins;
    assign tx_line_clock_out_o = s_q.tlclk;
    assign tx_positive_out_o = s_q.tpos;
    assign tx_negative_out_o = s_q.tneg;
    assign rx_clk_pin_o = s_q.rclk_pin;
    assign rx_frame_pin_o = s_q.rfr_pin;
    assign tx_clk_pin_o = s_q.tclk_pin;
    assign tx_frame_pin_o = s_q.tfr_pin;
    assign rx_aux_port_enable_o = s_q.pins.rx_aux_port_enable;
    assign tx_aux_port_enable_o = s_q.pins.tx_aux_port_enable;
    assign ref8k_port_o = s_q.ref_port;
    assign ref8k_local_o = s_q.ref_local;
    assign verify_done_o = s_q.vdone;

endmodule // port_config_regs

// ### tb/port_config_regs_monitor.sv
`timescale 1ns/1ps
module port_config_regs_monitor
    import port_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic tx_positive_i,
    input wire logic tx_positive_out_o,
    input wire logic tx_line_clock_i,
    input wire logic tx_line_clock_out_o,
    input wire logic tx_negative_i,
    input wire logic tx_negative_out_o,
    input wire logic tx_clock_output_i,
    input wire logic tx_overhead_clock_i,
    input wire logic tx_gapped_clock_i,
    input wire logic ohclk_not_gapped_i,
    input wire logic tx_clk_pin_o,
    input wire logic rx_clk_drive_low_i,
    input wire logic rx_clock_output_i,
    input wire logic rx_clk_pin_o,
    input wire logic rx_start_of_frame_i,
    input wire logic rx_data_enable_i,
    input wire logic rx_frame_pin_o,
    input wire logic tx_start_of_frame_i,
    input wire logic tx_data_enable_i,
    input wire logic tx_frame_pin_o,
    input wire logic rx_aux_port_enable_o,
    input wire logic tx_aux_port_enable_o,
    input wire logic rx_plcp_8k_i,
    input wire logic rx_line_clock_in_i,
    input wire logic tx_framer_8k_i,
    input wire logic ref8k_port_o,
    input wire logic global_8k_i,
    input wire logic ref8k_local_o,
    input wire logic [3:0] good_cells_i,
    input wire logic verify_done_o,
    input wire mode_cfg_t mode_o,
    input wire pin_cfg_t pins_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers one cycle after a taken request, for one cycle
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
    // Gated line output and pin muxes lag their sources by one cycle
    a_line_gate: assert property (
        tx_positive_out_o == ($past(tx_positive_i) && pins_o.tx_line_out_enable)) else $error("line");
    a_line_clock: assert property (
        tx_line_clock_out_o == ($past(tx_line_clock_i) && pins_o.tx_line_out_enable))
        else $error("line clock");
    a_line_negative: assert property (
        tx_negative_out_o == ($past(tx_negative_i) && pins_o.tx_line_out_enable))
        else $error("line negative");
    a_tx_clk_sel: assert property (!$past(rst_i) |-> tx_clk_pin_o ==
        (pins_o.tx_clk_pin_select ? $past(tx_clock_output_i) : ($past(ohclk_not_gapped_i) ?
        $past(tx_overhead_clock_i) : $past(tx_gapped_clock_i)))) else $error("txclk");
    a_rx_clk_low: assert property (!$past(rst_i) && !pins_o.rx_clk_pin_select &&
        $past(rx_clk_drive_low_i) |-> !rx_clk_pin_o) else $error("rxclk low");
    a_rx_clk_sel: assert property (
        pins_o.rx_clk_pin_select |-> rx_clk_pin_o == $past(rx_clock_output_i)) else $error("rxclk");
    a_rx_frame_sel: assert property (!$past(rst_i) |-> rx_frame_pin_o ==
        (pins_o.rx_frame_pin_select ? $past(rx_start_of_frame_i) : $past(rx_data_enable_i)))
        else $error("rxframe");
    a_tx_frame_sel: assert property (!$past(rst_i) |-> tx_frame_pin_o ==
        (pins_o.tx_frame_pin_select ? $past(tx_start_of_frame_i) : $past(tx_data_enable_i)))
        else $error("txframe");
    a_aux_enables: assert property ({rx_aux_port_enable_o, tx_aux_port_enable_o} ==
        {pins_o.rx_aux_port_enable, pins_o.tx_aux_port_enable}) else $error("aux");
    a_ref_port: assert property (!$past(rst_i) |-> ref8k_port_o ==
        (!pins_o.ref8k_port_source[1] ? $past(rx_plcp_8k_i) : pins_o.ref8k_port_source[0] ?
        $past(tx_framer_8k_i) : $past(rx_line_clock_in_i))) else $error("refport");
    a_ref_global: assert property (!$past(rst_i) && !pins_o.ref8k_use_port |->
        ref8k_local_o == $past(global_8k_i)) else $error("refglobal");
    a_verify_done: assert property (!$past(rst_i) |->
        verify_done_o == ($past(good_cells_i) >= mode_o.verify_count)) else $error("verify");
    a_mask_unipolar: assert property (
        mode_o.overhead_mask |-> mode_o.code == CODE_UNI) else $error("mask code");
    // Main scenarios reached
    cover property (ack_o && pins_o.tx_line_out_enable);
    cover property (mode_o.plcp && !mode_o.proc_delineates);
    cover property (verify_done_o && mode_o.verify_count == 4'h8);
endmodule // port_config_regs_monitor

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import port_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic packet_bus_mode_i = 1'b1, zero_suppress_disable_i = 1'b0;
    logic [3:0] good_cells_i = 4'h0;
    logic [18:0] pat = 19'h0;
    logic [31:0] dat_o;
    logic ack_o, tx_line_clock_out_o, tx_positive_out_o, tx_negative_out_o, rx_clk_pin_o;
    logic rx_frame_pin_o, tx_clk_pin_o, tx_frame_pin_o, rx_aux_port_enable_o;
    logic tx_aux_port_enable_o, ref8k_port_o, ref8k_local_o, verify_done_o;
    mode_cfg_t mode_o, em;
    pin_cfg_t pins_o;
    int err_total = 0, n_checks = 0, ticks = 0;
    logic [15:0] q;

    port_config_regs DUT (.*,
        .tx_line_clock_i(pat[0]), .tx_positive_i(pat[1]), .tx_negative_i(pat[2]),
        .rx_overhead_clock_i(pat[3]), .rx_gapped_clock_i(pat[4]), .rx_clock_output_i(pat[5]),
        .rx_start_of_frame_i(pat[6]), .rx_data_enable_i(pat[7]), .tx_overhead_clock_i(pat[8]),
        .tx_gapped_clock_i(pat[9]), .tx_clock_output_i(pat[10]), .tx_start_of_frame_i(pat[11]),
        .tx_data_enable_i(pat[12]), .ohclk_not_gapped_i(pat[13]), .rx_clk_drive_low_i(pat[14]),
        .rx_plcp_8k_i(pat[15]), .rx_line_clock_in_i(pat[16]), .tx_framer_8k_i(pat[17]),
        .global_8k_i(pat[18]));

    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Candidate pin signals keep moving; hang guard
    always @(posedge clk_i) begin
        pat <= pat * 19'h5 + 19'h1;
        ticks <= ticks + 1;
        if (ticks == 40000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        input logic [3:0] s);
        @(posedge clk_i);
        adr_i <= a;
        dat_i <= {16'h0000, d};
        sel_i <= s;
        we_i <= w;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000, 4'hF);
        chk(q, e);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // Expected decode of a control two image
    function automatic mode_cfg_t exp_mode(input logic [10:0] c, input logic z,
                                           input logic p);
        mode_cfg_t m;
        logic rsv;
        m = '0;
        if (!c[5]) begin
            m.family = frame_family_t'({1'b0, c[4:3]});
            m.sub = frame_sub_t'(c[2:0]);
            rsv = (c[2:0] == 3'h7) || (c[4:3] == 2'h3 && c[2:1] == 2'h2);
        end else begin
            m.family = c[4] ? FR_CC_E3 : (c[3] ? FR_CC_STS1 : FR_CC_DS3);
            m.sub = !c[0] ? SUB_PLAIN : (c[1] ? SUB_MASK_OCTET : SUB_MASK);
            rsv = c[2];
        end
        if (rsv) begin
            m.family = FR_DS3_CBIT;
            m.sub = SUB_PLAIN;
        end
        m.plcp = m.sub inside {SUB_PLCP, SUB_PLCP_MASK};
        m.overhead_mask = m.sub inside {SUB_MASK, SUB_PLCP_MASK, SUB_MASK_OCTET};
        m.code = (c[7] || m.overhead_mask) ? CODE_UNI : (z ? CODE_AMI : CODE_B3ZS_HDB3);
        m.cell_proc = !p || c[10] || m.plcp;
        m.proc_delineates = !(c[6] && m.plcp);
        m.verify_count = c[8] ? 4'h8 : 4'h6;
        return m;
    endfunction

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL2_ADDR, 16'h0000);
        rd(CTRL3_ADDR, 16'h0000);
        xfer(1'b1, CTRL2_ADDR, 16'hFFFF, 4'hF);
        rd(CTRL2_ADDR, 16'h8CFF);
        xfer(1'b1, CTRL3_ADDR, 16'hFFFF, 4'hF);
        rd(CTRL3_ADDR, 16'h3FE0);
        xfer(1'b1, CTRL2_ADDR, 16'h0000, 4'h2);
        rd(CTRL2_ADDR, 16'h00FF);
        xfer(1'b1, 8'h46, 16'hFFFF, 4'hF);
        rd(8'h46, 16'h0000);
        rd(CTRL2_ADDR, 16'h00FF);
        // Every framing code with each combination of the other control bits; line enable follows code bit 3
        for (int i = 0; i < 2048; i++) begin
            zero_suppress_disable_i <= i[9];
            packet_bus_mode_i <= i[0] ^ i[2];
            good_cells_i <= i[3:0];
            xfer(1'b1, CTRL2_ADDR, {i[3], 3'h0, i[8:7], 2'h0, i[6], i[10], i[5:0]}, 4'hF);
            settle();
            em = exp_mode(i[10:0], i[9], i[0] ^ i[2]);
            chk(mode_o, em);
            chk(verify_done_o, i[3:0] >= em.verify_count);
            chk(pins_o.tx_line_out_enable, i[3]);
        end
        // Every pin selection and reference source
        for (int k = 0; k < 512; k++) begin
            xfer(1'b1, CTRL3_ADDR, {2'h0, k[8:0], 5'h1F}, 4'hF);
            settle();
            chk(pins_o, {1'b1, k[8:3], k[0], k[2:1]});
            chk({rx_aux_port_enable_o, tx_aux_port_enable_o}, {k[6], k[3]});
        end
        results();
    end
endmodule // testbench

bind port_config_regs port_config_regs_monitor mon (.*);
